// ---- include/ieb_regs.vh ----
// register offsets, implemented-bit masks and reset values for the enable bank
// Notes on behaviour
// - enable bit at one lets its source request through; zero blocks it.
// - unimplemented enable bits read zero and ignore writes.
// - implemented enable bits are read/write and clear to zero at reset.
// - first register bit 1 gates capture 1, bit 0 external pin 0.
// - second register upper byte: uart2 tx/rx, pin2, timers 5/4, compares 4/3.
// - second register lower byte: captures 8/7, pin1, change, comparator, i2c1.
// - third register: parallel port, compares 8-5, captures 6-3, spi2 event/fault.
// - parallel port enable is absent and reads zero on small packages.
// - fourth register: calendar, pins 4/3, i2c2 master and slave.
// - fifth register: charge time, low volt, crc, uart2 and uart1 errors.
// - sixth register upper byte: capture 9, compare 9, spi3, uart4 tx/rx.
// - sixth register lower byte: uart4 err, usb, i2c3, uart3 tx/rx/err.
// - flag bits set by hardware on request regardless of enable; software clears.
`ifndef IEB_REGS_VH
`define IEB_REGS_VH

`define IEB_NUM_REGS        6
`define IEB_REG_W           16
// enable registers, one aligned word each
`define IEB_OFF_ENABLE_0    12'h000
`define IEB_OFF_ENABLE_1    12'h004
`define IEB_OFF_ENABLE_2    12'h008
`define IEB_OFF_ENABLE_3    12'h00C
`define IEB_OFF_ENABLE_4    12'h010
`define IEB_OFF_ENABLE_5    12'h014
// flag registers
`define IEB_OFF_FLAG_0      12'h020
`define IEB_OFF_FLAG_5      12'h034
// implemented bits per register
`define IEB_MASK_0          16'h3FEF
`define IEB_MASK_1          16'hFEDF
`define IEB_MASK_2          16'h3FE3
`define IEB_MASK_3          16'h4066
`define IEB_MASK_4          16'h210E
`define IEB_MASK_5          16'h3FFE
// parallel port enable position in the third register
`define IEB_PARPORT_BIT     13
`define IEB_RESET_VAL       16'h0000

`endif

// ---- hdl/ieb_top.v ----
// interrupt enable and flag bank behind an ahb-lite slave port
//
// Decided for this implementation: the AHB-Lite interface to the registers and the register addresses.
`include "ieb_regs.vh"

module ieb_top #(
    parameter SMALL_PKG = 0                 // 1: drop the parallel port bit
) (
    input  wire        hclk,                // bus clock, 25 MHz
    input  wire        hresetn,             // async reset, active low
    input  wire        hsel,                // slave select
    input  wire [31:0] haddr,               // byte address
    input  wire [1:0]  htrans,              // transfer type
    input  wire        hwrite,              // 1 write, 0 read
    input  wire [2:0]  hsize,               // transfer size
    input  wire        hready,              // bus ready in
    input  wire [31:0] hwdata,              // write data
    output reg  [31:0] hrdata,              // read data
    output reg         hreadyout,           // slave ready
    output reg         hresp,               // response, always okay
    input  wire [95:0] src_req,             // source request pulses, 16/reg
    output reg  [95:0] irq_pending,         // flag and enable, per source
    output reg         irq_any              // any request forwarded
);

    localparam NR = `IEB_NUM_REGS;
    localparam RW = `IEB_REG_W;
    localparam [95:0] MASK_FULL = {`IEB_MASK_5, `IEB_MASK_4,
                                   `IEB_MASK_3, `IEB_MASK_2,
                                   `IEB_MASK_1, `IEB_MASK_0};
    localparam [95:0] PARPORT_CLR =
        96'h0000_0000_0000_0000_0000_0001 << (2 * RW + `IEB_PARPORT_BIT);
    // small packages lose the parallel port enable entirely
    localparam [95:0] MASK = (SMALL_PKG != 0) ? (MASK_FULL & ~PARPORT_CLR)
                                              : MASK_FULL;

    // register index of an address, bit 3 set when it is a flag register,
    // bit 4 set when the address hits anything at all
    function [4:0] ieb_decode;
        input [11:0] a;
        begin
            ieb_decode = 5'h00;
            if (a >= `IEB_OFF_ENABLE_0 && a <= `IEB_OFF_ENABLE_5)
                ieb_decode = {2'b10, a[4:2]};
            else if (a >= `IEB_OFF_FLAG_0 && a <= `IEB_OFF_FLAG_5)
                ieb_decode = {2'b11, a[4:2] - 3'h0};
        end
    endfunction

    // bank state, flattened one register per 16-bit slice
    reg  [95:0] enable_r;
    reg  [95:0] flag_r;
    wire [95:0] enable_nxt;
    wire [95:0] flag_nxt;

    // captured address phase of a pending write
    reg         wr_pend_r;
    reg  [4:0]  wr_dec_r;

    wire        addr_ok = hsel & hready & htrans[1];
    wire [4:0]  dec_now = ieb_decode(haddr[11:0]);
    wire [2:0]  fl_idx  = dec_now[2:0];

    // address phase capture; only word transfers are expected
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_r <= 1'b0;
            wr_dec_r  <= 5'h00;
        end
        else
        begin
            wr_pend_r <= addr_ok & hwrite;
            wr_dec_r  <= dec_now;
        end
    end

    // per-register next values
    genvar g;
    generate
        for (g = 0; g < NR; g = g + 1)
        begin : g_reg
            wire hit_en = wr_pend_r & wr_dec_r[4] & ~wr_dec_r[3]
                          & (wr_dec_r[2:0] == g);
            wire hit_fl = wr_pend_r & wr_dec_r[4] & wr_dec_r[3]
                          & (wr_dec_r[2:0] == g);
            wire [RW-1:0] m = MASK[g*RW +: RW];
            // unimplemented positions never take a write
            assign enable_nxt[g*RW +: RW] =
                (hit_en ? hwdata[RW-1:0] : enable_r[g*RW +: RW]) & m;
            // hardware set wins over a same-cycle software clear
            assign flag_nxt[g*RW +: RW] =
                ((hit_fl ? hwdata[RW-1:0] : flag_r[g*RW +: RW])
                 | src_req[g*RW +: RW]) & m;
        end
    endgenerate

    // bank registers: everything off after reset
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            enable_r <= {NR{`IEB_RESET_VAL}};
            flag_r   <= {NR{`IEB_RESET_VAL}};
        end
        else
        begin
            enable_r <= enable_nxt;
            flag_r   <= flag_nxt;
        end
    end

    // forward requests; registered so outputs come straight from flops
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            irq_pending <= 96'h0000_0000_0000_0000_0000_0000;
            irq_any     <= 1'b0;
        end
        else
        begin
            irq_pending <= flag_r & enable_r;
            irq_any     <= |(flag_r & enable_r);
        end
    end

    // read mux works on next values so a read right after a write
    // sees the freshly written data
    reg [15:0] rd_word;
    always @*
    begin
        rd_word = 16'h0000;
        if (dec_now[4] && fl_idx < NR)
        begin
            if (dec_now[3])
                rd_word = flag_nxt[fl_idx*RW +: RW];
            else
                rd_word = enable_nxt[fl_idx*RW +: RW];
        end
    end

    // data phase outputs; zero wait states, always okay
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (addr_ok && !hwrite)
                hrdata <= {16'h0000, rd_word};
            else
                hrdata <= 32'h0000_0000;
        end
    end

endmodule // ieb_top

// ---- sim/ieb_top_properties.sv ----
// concurrent checks on the enable bank's bus and request ports
module ieb_props #(
    parameter SMALL_PKG = 0            // 1: parallel port bit absent
) (
    input logic        hclk,           // bus clock
    input logic        hresetn,        // reset, active low
    input logic        hsel,           // slave select
    input logic [1:0]  htrans,         // transfer type
    input logic        hwrite,         // write strobe
    input logic        hready,         // bus ready in
    input logic [31:0] hrdata,         // read data
    input logic        hreadyout,      // slave ready
    input logic        hresp,          // response
    input logic [95:0] src_req,        // request pulses
    input logic [95:0] irq_pending,    // gated requests
    input logic        irq_any         // any request
);
    timeunit 1ns;
    timeprecision 1ns;
    // implemented positions, small package drops the parallel port
    localparam logic [95:0] IMPL = 96'h3FFE_210E_4066_3FE3_FEDF_3FEF &
        ~(SMALL_PKG ? 96'h2000_0000_0000 : 96'h0);
    logic rd;
    logic wr;
    // taken transfers
    assign rd = hsel && hready && htrans[1] && !hwrite;
    assign wr = hsel && hready && htrans[1] && hwrite;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    ready_high_a: assert property (hreadyout) else $error("ready low");
    resp_okay_a: assert property (!hresp) else $error("bad response");
    upper_zero_a: assert property (hrdata[31:16] == 16'h0000)
        else $error("upper read bits set");
    idle_data_a: assert property (!$past(rd) |-> hrdata == 32'h0000_0000)
        else $error("read data outside data phase");
    pend_impl_a: assert property ((irq_pending & ~IMPL) == 96'h0)
        else $error("pending on absent bit");
    any_or_a: assert property (irq_any == |irq_pending)
        else $error("any differs from pending");
    // a forwarded request only drops after software writes
    pend_fall_a: assert property ($fell(irq_any) |-> $past(wr, 3))
        else $error("pending dropped without write");
    pend_rise_a: assert property ($rose(irq_any) |->
        $past(wr, 3) || $past(|src_req, 2))
        else $error("pending rose without cause");
    cover property (rd);
    cover property ($rose(irq_any));
    cover property ($fell(irq_any));
endmodule // ieb_props

// ---- sim/ieb_src_model.sv ----
// request source model: one-cycle pulses on command
module ieb_src_model (
    input  logic        hclk,          // bus clock
    input  logic        go,            // fire at next edge
    input  logic [6:0]  idx,           // source index
    output logic [95:0] src_req = 96'h0 // request pulses
);
    timeunit 1ns;
    timeprecision 1ns;
    // pin sources are taken as routed to a pin already
    always @(posedge hclk)
    begin
        src_req <= go ? 96'h1 << idx : 96'h0;
    end
endmodule // ieb_src_model

// ---- sim/ieb_top_tb.sv ----
// testbench for the enable bank: map, reset values, gating and flags
module ieb_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [95:0] src_req, irq_pending;
    logic [1:0]  htrans;
    logic [6:0]  idx;
    logic        hclk, hresetn, hwrite, hreadyout, hresp, irq_any, go;
    int          fails, checks, cyc;
    // masks per register; small package loses bit 13 of the third
    logic [15:0] msk [6] = '{16'h3FEF, 16'hFEDF, 16'h1FE3,
                             16'h4066, 16'h210E, 16'h3FFE};
    ieb_top #(.SMALL_PKG(1)) uut (.hclk(hclk), .hresetn(hresetn),
        .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'b010), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .src_req(src_req), .irq_pending(irq_pending), .irq_any(irq_any));
    ieb_src_model src (.hclk(hclk), .go(go), .idx(idx), .src_req(src_req));
    initial
    begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    // hang guard well above the expected 176 or so cycles
    always @(posedge hclk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            fails++;
            report_and_stop;
        end
    end
    task automatic report_and_stop;
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [95:0] got, input logic [95:0] exp);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one single transfer, read data taken at the data phase edge
    task automatic bus(input logic [11:0] a, input logic w,
                       input logic [15:0] d);
        @(posedge hclk);
        haddr <= {20'h0_0000, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= {16'h0000, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    // go raised at edge 1, pulse lands at edge 2, flag at 3, pending at 4
    task automatic pulse(input logic [6:0] i);
        @(posedge hclk);
        go <= 1'b1;
        idx <= i;
        @(posedge hclk);
        go <= 1'b0;
        repeat (2) @(posedge hclk);
        #1;
    endtask
    // enables then flags: reset value, all ones, cleared again
    task automatic t_map;
        logic [11:0] a;
        for (int k = 0; k < 12; k++)
        begin
            a = 12'(4 * k + (k > 5 ? 8 : 0));
            bus(a, 1'b0, 16'h0000);
            chk(r, '0);
            bus(a, 1'b1, 16'hFFFF);
            bus(a, 1'b0, 16'h0000);
            chk(r, msk[k % 6]);
            bus(a, 1'b1, 16'h0000);
        end
        bus(12'h040, 1'b1, 16'hFFFF);
        bus(12'h040, 1'b0, 16'h0000);
        chk(r, '0);
    endtask
    // gate external pin 2, then block it with its flag still set
    task automatic t_gate;
        bus(12'h004, 1'b1, 16'h2000);
        pulse(7'd29);
        chk(irq_pending, 96'h2000_0000);
        chk({95'h0, irq_any}, 96'h1);
        bus(12'h004, 1'b1, 16'h0000);
        @(posedge hclk);
        #1;
        chk(irq_pending, '0);
        pulse(7'd24);
        bus(12'h024, 1'b0, 16'h0000);
        chk(r, 96'h2000);
        bus(12'h024, 1'b1, 16'h0000);
        bus(12'h024, 1'b0, 16'h0000);
        chk(r, '0);
    endtask
    initial
    begin
        hresetn = 1'b0;
        htrans = 2'b00;
        hwrite = 1'b0;
        haddr = 32'h0000_0000;
        hwdata = 32'h0000_0000;
        go = 1'b0;
        idx = 7'h00;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        t_map;
        t_gate;
        report_and_stop;
    end
endmodule // ieb_top_tb
bind ieb_top ieb_props #(.SMALL_PKG(SMALL_PKG)) chk_i (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .src_req(src_req), .irq_pending(irq_pending),
    .irq_any(irq_any));
